// File: rtl/rx_fifo_ctl.sv
// Receive FIFO control: admission, request flag, idle timeout, APB regs
//
// Behaviour
// - request flag high exactly while FIFO level exceeds threshold.
// - timeout on, FIFO non-empty, not above threshold, expired: interrupt.
// - with timeout disabled, lingering bytes never cause an interrupt.
// - FIFO enable high (reset value) stores every received byte unless the FIFO is full or clk_en is low.
// - FIFO enable low discards every received byte.
// - request flag is hardware set, read-only, resets to zero.
`timescale 1ns/1ps
`include "rx_fifo_ctl_defs.svh"
module rx_fifo_ctl
  import rx_fifo_ctl_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int CW    = 16,
  parameter int TOUT_CYC = `TOUT_CYCLES
)(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Received bytes from the shift engine
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  // Status outputs
  output logic             rx_fifo_request,
  output logic             irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]    ctrl_q;
  logic [2:0]    istat_q;
  logic [2:0]    imask_q;
  logic [CW-1:0] tout_q;
  logic          req_q;
  logic          irq_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;
  logic [7:0]    rd_data;
  logic [AW:0]   level;
  logic          expired;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire acc      = psel && penable && !pready_q;
  wire wr       = acc && pwrite;
  wire rd       = acc && !pwrite;
  wire hit_ctrl = paddr == `OFS_CTRL;
  wire hit_st   = paddr == `OFS_STATUS;
  wire hit_is   = paddr == `OFS_INT_STAT;
  wire hit_im   = paddr == `OFS_INT_MASK;
  wire hit_dat  = paddr == `OFS_RX_DATA;
  wire hit_to   = paddr == `OFS_TIMEOUT;
  wire mapped   = hit_ctrl | hit_st | hit_is | hit_im | hit_dat | hit_to;

  wire       fifo_en   = ctrl_q[`CTRL_FIFO_EN_BIT];
  wire       tout_en   = ctrl_q[`CTRL_TOUT_EN_BIT];
  wire [2:0] threshold = ctrl_q[`CTRL_THR_LSB +: 3];
  wire       full      = level == (AW+1)'(DEPTH);
  // Stored only when enabled; a full FIFO also drops, flagged below
  wire       store     = rx_valid && fifo_en && !full;
  wire       drop      = rx_valid && fifo_en && full;
  // An empty FIFO is never popped, so the level cannot wrap
  wire       pop       = rd && hit_dat && level != '0;
  wire [AW:0] lvl_next = level + (AW+1)'(store) - (AW+1)'(pop);
  // Next threshold, so a control write and a level change agree at once
  wire [2:0] thr_next  = (wr && hit_ctrl) ? pwdata[`CTRL_THR_LSB +: 3]
                                           : threshold;
  // Comparing against next level keeps the flag in step with the count
  wire       req_d     = lvl_next > (AW+1)'(thr_next);
  // Lingering: bytes present but not above the threshold
  wire       linger    = tout_en && level != '0 &&
                         level <= (AW+1)'(threshold);
  wire [2:0] ev        = {drop, req_d && !req_q, expired && linger};
  wire [2:0] w1c       = (wr && hit_is) ? pwdata[2:0] : 3'h0;

  // ----------------------------------------------------------------
  // Storage and timer
  // ----------------------------------------------------------------
  rx_byte_store #(.DEPTH(DEPTH), .AW(AW)) u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_valid(store),
    .wr_data (rx_byte),
    .rd_pop  (pop),
    .rd_data (rd_data),
    .level   (level)
  );

  // Count restarts on each stored byte, not on pops
  idle_timer #(.CW(CW)) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .arm     (linger),
    .restart (store),
    .limit   (tout_q),
    .expired (expired)
  );

  // Read mux; reserved bit 2 reads back as stored
  wire [31:0] rmux =
      hit_ctrl ? {24'h0, ctrl_q[7:4], req_q, ctrl_q[2:0]} :
      hit_st   ? {{(31-AW){1'b0}}, level} :
      hit_is   ? {29'h0, istat_q} :
      hit_im   ? {29'h0, imask_q} :
      hit_dat  ? {24'h0, rd_data} :
      hit_to   ? {{(32-CW){1'b0}}, tout_q} : 32'h0;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Request bit position is masked off: software cannot touch it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= `CTRL_RESET;
      imask_q <= `INT_MASK_RESET;
      tout_q  <= CW'(TOUT_CYC);
    end
    else if (clk_en && wr)
    begin
      if (hit_ctrl) ctrl_q <= pwdata[7:0] & 8'hF7;
      if (hit_im)   imask_q <= pwdata[2:0];
      if (hit_to)
        tout_q <= (pwdata[CW-1:0] == '0) ? CW'(1) : pwdata[CW-1:0];
    end
  end

  // Sticky status; a same-cycle event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_q <= 3'h0;
    else if (clk_en)
      istat_q <= (istat_q & ~w1c) | ev;
  end

  // Flag, interrupt and bus answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q     <= 1'b0;
      irq_q     <= 1'b0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else if (clk_en)
    begin
      req_q     <= req_d;
      irq_q     <= |(((istat_q & ~w1c) | ev) & imask_q);
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q  <= rd ? rmux : 32'h0;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign rx_fifo_request = req_q;
  assign irq             = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Flag follows the level it was computed for
  req_tracks_level_a: assert property (
    clk_en |=> rx_fifo_request == (level > (AW+1)'(threshold)))
    else $error("request flag disagrees with level");

  // Control writes leave the flag to hardware
  req_ro_a: assert property (
    (wr && hit_ctrl && clk_en) |=> rx_fifo_request == $past(req_d))
    else $error("software write moved request flag");

  // Enabled, room left, no pop: level grows by one
  store_when_en_a: assert property (
    (clk_en && rx_valid && fifo_en && !full && !pop) |=>
      level == $past(level) + 1'b1)
    else $error("enabled byte not stored");

  // Disabled: the byte leaves no trace in the level
  discard_when_off_a: assert property (
    (clk_en && rx_valid && !fifo_en && !pop) |=> level == $past(level))
    else $error("disabled byte was stored");

  // Timeout flag may stay but never rise while disabled
  no_tout_off_a: assert property (
    !tout_en |=> !istat_q[`INT_TOUT_BIT] || $past(istat_q[`INT_TOUT_BIT]))
    else $error("timeout flag set while disabled");

  // Expiry while lingering is recorded
  tout_cause_a: assert property (
    (clk_en && expired && linger) |=> istat_q[`INT_TOUT_BIT])
    else $error("expired timeout not flagged");

  // Lingering without a new byte; the timer may run on
  sequence quiet_s;
    clk_en && !store && linger;
  endsequence
  // A stored byte always takes the timer out of the fired state
  timer_restart_a: assert property (
    (clk_en && store) |=> !expired)
    else $error("timer not restarted by stored byte");

  // Leaving the lingering state stands the timer down
  timer_disarm_a: assert property (
    quiet_s ##1 (clk_en && !linger) |=> !expired)
    else $error("timer still expired after disarm");

  // No unmasked status and no event: the interrupt stays low
  irq_mask_a: assert property (
    (clk_en && (istat_q & imask_q) == 3'h0 && ev == 3'h0) |=> !irq)
    else $error("interrupt without unmasked status");

  // Request position never lands in the control flops
  req_pos_clear_a: assert property (
    (clk_en && wr && hit_ctrl) |=> ctrl_q[`CTRL_REQ_BIT] == 1'b0)
    else $error("request position stored in control");

  // ----------------------------------------------------------------
  // Bus answer, status and freeze checks
  // ----------------------------------------------------------------
  // Access phase taken while running, and its answer
  sequence apb_take_s;
    clk_en && psel && penable && !pready;
  endsequence
  sequence apb_ans_s;
    clk_en && pready;
  endsequence

  // Exactly one wait cycle before the answer
  apb_answer_a: assert property (apb_take_s |=> pready)
    else $error("bus access not answered after one cycle");

  // The answer stands for one cycle only
  apb_pulse_a: assert property (apb_take_s ##1 apb_ans_s |=> !pready)
    else $error("bus answer held too long");

  // Error only ever rides on an answer
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error without answer");

  // Read data is zero outside the answer cycle
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");

  // Unmapped addresses are refused with an error
  unmapped_err_a: assert property ((clk_en && acc && !mapped) |=> pslverr)
    else $error("unmapped access not refused");

  // Set wins: an event is seen in status even beside its clear
  sticky_set_a: assert property (
    (clk_en && ev != 3'h0) |=> (istat_q & $past(ev)) == $past(ev))
    else $error("status event lost");

  // An unmasked event raises the interrupt at once
  irq_raise_a: assert property ((clk_en && (ev & imask_q) != 3'h0) |=> irq)
    else $error("unmasked event without interrupt");

  // A pop with no byte arriving lowers the level by one
  pop_level_a: assert property (
    (clk_en && pop && !store) |=> level == $past(level) - 1'b1)
    else $error("pop did not lower level");

  // An empty FIFO never lets the timer expire
  empty_no_tout_a: assert property (
    (clk_en && level == '0) |=> !expired)
    else $error("timer expired with empty FIFO");

  // Full FIFO: the byte is dropped, level kept, drop flagged
  drop_flag_a: assert property (
    (clk_en && rx_valid && fifo_en && full && !pop) |=>
      istat_q[`INT_DROP_BIT] && level == $past(level))
    else $error("overflow byte not dropped and flagged");

  // Enable low freezes level, flag, interrupt and bus answer
  state_freeze_a: assert property (
    !clk_en |=> level == $past(level) && irq == $past(irq) &&
      rx_fifo_request == $past(rx_fifo_request) && pready == $past(pready))
    else $error("state moved while enable low");
endmodule // rx_fifo_ctl

// File: rtl/rx_fifo_ctl_defs.svh
// Offsets, fields, reset values and timing counts of the rx FIFO control
`ifndef RX_FIFO_CTL_DEFS_SVH
`define RX_FIFO_CTL_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_INT_STAT    12'h008
`define OFS_INT_MASK    12'h00C
`define OFS_RX_DATA     12'h010
`define OFS_TIMEOUT     12'h014
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_FIFO_EN_BIT   0
`define CTRL_TOUT_EN_BIT   1
`define CTRL_RSVD_BIT      2
`define CTRL_REQ_BIT       3
`define CTRL_THR_LSB       4
`define CTRL_RESET         8'h01
// ----------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------
`define INT_TOUT_BIT       0
`define INT_REQ_BIT        1
`define INT_DROP_BIT       2
`define INT_MASK_RESET     3'h0
// ----------------------------------------------------------------
// Timing: idle timeout in ns, cycles at 5 ns clock
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      5
`define TOUT_NS            1000
`define TOUT_CYCLES        (`TOUT_NS / `CLK_PERIOD_NS)
`endif

// File: rtl/rx_fifo_ctl_pkg.sv
// Types shared by the rx FIFO control files
package rx_fifo_ctl_pkg;
  typedef enum logic [1:0] {
    TMR_IDLE  = 2'b00,
    TMR_COUNT = 2'b01,
    TMR_FIRED = 2'b10
  } tmr_state_t;
endpackage

// File: rtl/rx_byte_store.sv
// Flip-flop byte store for received data, indexed by pointers
`timescale 1ns/1ps
module rx_byte_store
  import rx_fifo_ctl_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW    = 3
)(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  // Fill side
  input  wire logic          wr_valid,
  input  wire logic [7:0]    wr_data,
  // Drain side
  input  wire logic          rd_pop,
  output logic      [7:0]    rd_data,
  output logic      [AW:0]   level
);
  logic [7:0]    mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           do_wr = wr_valid && (cnt_q != (AW+1)'(DEPTH));
  wire           do_rd = rd_pop && (cnt_q != '0);

  // Pointer wrap shared by both sides
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Storage has no reset; contents are only read below the level
  always_ff @(posedge pclk)
  begin
    if (clk_en && do_wr)
      mem_q[wp_q] <= wr_data;
  end

  // Pointers and level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (do_wr) wp_q <= nxt(wp_q);
      if (do_rd) rp_q <= nxt(rp_q);
      cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  assign rd_data = mem_q[rp_q];
  assign level   = cnt_q;
endmodule // rx_byte_store

// File: rtl/idle_timer.sv
// Idle timer restarted by each stored byte
`timescale 1ns/1ps
module idle_timer
  import rx_fifo_ctl_pkg::*;
#(
  parameter int CW = 16
)(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  // Control
  input  wire logic          arm,
  input  wire logic          restart,
  input  wire logic [CW-1:0] limit,
  // Result
  output logic               expired
);
  tmr_state_t    st_q;
  tmr_state_t    st_d;
  logic [CW-1:0] cnt_q;

  // Next state: a restart while armed counts again from zero; a disarm goes to idle
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      TMR_IDLE:  if (arm) st_d = TMR_COUNT;
      TMR_COUNT:
        if (!arm) st_d = TMR_IDLE;
        else if (!restart && cnt_q >= limit - 1'b1) st_d = TMR_FIRED;
      TMR_FIRED: if (!arm || restart) st_d = arm ? TMR_COUNT : TMR_IDLE;
      default:   st_d = TMR_IDLE;
    endcase
  end

  // State and count registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= TMR_IDLE;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      st_q  <= st_d;
      cnt_q <= (st_d != TMR_COUNT || restart || st_q != TMR_COUNT)
               ? '0 : cnt_q + 1'b1;
    end
  end

  assign expired = (st_q == TMR_FIRED);
endmodule // idle_timer

// File: sim/rx_fifo_ctl_test.sv
// Self-checking testbench for the rx FIFO control block
`timescale 1ns/1ps
`include "rx_fifo_ctl_defs.svh"
module rx_fifo_ctl_test;
  // ------------------------------------------------------------
  // Signals and design
  // ------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        rx_fifo_request;
  logic        irq;
  int          error_cnt = 0;
  int          n_checks = 0;

  // Short timeout keeps the idle scenarios quick
  rx_fifo_ctl #(.TOUT_CYC(20)) dut (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_fifo_request(rx_fifo_request), .irq(irq));

  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Compare, bus and stream tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      error_cnt++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t %s got %b exp %b", $time, msg, got, exp);
      error_cnt++;
    end
  endtask

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) chk_bit(1'b0, 1'b1, "bus hang");
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps the release apart from the next setup
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk_bit(e, 1'b0, "write error");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
    chk_bit(e, 1'b0, "read error");
  endtask

  // One byte pulse, then time for level and flag to settle
  task automatic send(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_byte  <= b;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_byte  <= ~b;
    repeat (2) @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk_bit(rx_fifo_request, 1'b0, "req at reset");
    chk_bit(irq, 1'b0, "irq at reset");
    rd(`OFS_CTRL, 32'h0000_0001);
    rd(`OFS_INT_MASK, 32'h0000_0000);
    rd(`OFS_STATUS, 32'h0000_0000);
  endtask

  // Threshold two: flag only above two bytes, read-only to software
  task automatic t_store;
    wr(`OFS_CTRL, 32'h0000_0021);
    send(8'hA1);
    send(8'hA2);
    chk_bit(rx_fifo_request, 1'b0, "req at thr");
    send(8'hA3);
    chk_bit(rx_fifo_request, 1'b1, "req above thr");
    rd(`OFS_STATUS, 32'h0000_0003);
    rd(`OFS_RX_DATA, 32'h0000_00A1);
    repeat (2) @(posedge pclk);
    chk_bit(rx_fifo_request, 1'b0, "req after pop");
    wr(`OFS_CTRL, 32'h0000_0029);
    rd(`OFS_CTRL, 32'h0000_0021);
    chk_bit(rx_fifo_request, 1'b0, "req written");
    rd(`OFS_RX_DATA, 32'h0000_00A2);
    rd(`OFS_RX_DATA, 32'h0000_00A3);
    rd(`OFS_STATUS, 32'h0000_0000);
  endtask

  task automatic t_discard;
    wr(`OFS_CTRL, 32'h0000_0020);
    send(8'h5C);
    rd(`OFS_STATUS, 32'h0000_0000);
  endtask

  // Timeout off: a lingering byte stays silent
  task automatic t_tout_off;
    wr(`OFS_CTRL, 32'h0000_0021);
    wr(`OFS_INT_STAT, 32'h0000_0007);
    wr(`OFS_INT_MASK, 32'h0000_0001);
    send(8'h3E);
    repeat (60) @(posedge pclk);
    chk_bit(irq, 1'b0, "irq with timeout off");
    rd(`OFS_INT_STAT, 32'h0000_0000);
  endtask

  // A second byte restarts the idle count, then the interrupt fires
  task automatic t_tout_on;
    int n;
    rd(`OFS_RX_DATA, 32'h0000_003E);
    wr(`OFS_TIMEOUT, 32'h0000_0014);
    wr(`OFS_INT_STAT, 32'h0000_0007);
    wr(`OFS_CTRL, 32'h0000_0023);
    send(8'h11);
    repeat (12) @(posedge pclk);
    send(8'h22);
    repeat (12) @(posedge pclk);
    chk_bit(irq, 1'b0, "irq before restart ran out");
    n = 0;
    while (irq !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge pclk);
    end
    chk_bit(irq, 1'b1, "irq after idle");
    rd(`OFS_INT_STAT, 32'h0000_0001);
    wr(`OFS_INT_MASK, 32'h0000_0000);
    @(posedge pclk);
    chk_bit(irq, 1'b0, "irq masked");
    wr(`OFS_CTRL, 32'h0000_0021);
    rd(`OFS_RX_DATA, 32'h0000_0011);
    rd(`OFS_RX_DATA, 32'h0000_0022);
    wr(`OFS_INT_STAT, 32'h0000_0001);
    rd(`OFS_INT_STAT, 32'h0000_0000);
    wr(`OFS_INT_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b0, "irq after clear");
  endtask

  // Nine bytes into eight places, then a byte offered while frozen
  task automatic t_overflow;
    for (int i = 0; i < 9; i++)
      send(8'h40 + 8'(i));
    rd(`OFS_STATUS, 32'h0000_0008);
    rd(`OFS_INT_STAT, 32'h0000_0006);
    chk_bit(irq, 1'b0, "irq with events masked");
    rd(`OFS_RX_DATA, 32'h0000_0040);
    clk_en <= 1'b0;
    send(8'h77);
    clk_en <= 1'b1;
    rd(`OFS_STATUS, 32'h0000_0007);
  endtask

  task automatic t_unmapped;
    logic [31:0] q;
    logic        e;
    apb(1'b0, 12'h100, 32'h0, q, e);
    chk(q, 32'h0000_0000, "unmapped data");
    chk_bit(e, 1'b1, "unmapped error");
  endtask

  // ------------------------------------------------------------
  // Sequence, verdict and watchdog
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence; clk_en drops only in the overflow scenario
  initial
  begin
    presetn  = 1'b0;
    clk_en   = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_store;
    t_discard;
    t_tout_off;
    t_tout_on;
    t_overflow;
    t_unmapped;
    end_of_test;
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    #50000;
    chk_bit(1'b0, 1'b1, "watchdog");
    end_of_test;
  end
endmodule // rx_fifo_ctl_test
